// *** logic/preset_timer.sv ***
// single or dual preset interval timer with apb set-up registers
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
// Behaviour
// - single mode 6: count up, pulse at preset, then clear and restart
// - single mode 8: count down, latch output at zero, reset reloads
// - dual-only modes are not run by the single-preset variant
// - dual mode 2: out1 on at sp1; sp2 drops out1, latches out2
// - dual mode 3: as mode 2 but out2 is a timed pulse
// - dual mode 4: at sp2 pulse out2, drop out1, clear count
// - dual mode 5: both outputs pulsed, count clears at sp2
// - dual mode 6: at sp2 drop out1, pulse out2, restart after pulse
// - dual mode 7: both pulsed, count restarts when out2 pulse ends
// - dual mode 8: count down, latch out1 at sp1, out2 at zero
// - dual mode 9: count down, pulses at sp1 and at zero
// - dual mode 10: down; out1 at sp1; zero drops out1, latches out2
// - dual mode 11: down; zero drops out1 and pulses out2
// - check stored set-up at power-up, raise fault flag on mismatch
// - fault leaves timing running and clears only on accept key
// - manual reset from key or remote input restarts from start count
// - remote reset held low keeps outputs off and count at reset value
// - count advances only while the run input is active
// - pulse durations limited to 0.01 to 99.99 seconds
module preset_timer
	import timer_pkg::*;
#(
	parameter bit          DUAL        = 1'b1,
	parameter int unsigned TICK_CYCLES = TICK_CYC
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             run_in_n,
	input  wire logic             external_clear_input_n,
	input  wire logic [SUM_W-1:0] nv_sum,
	output logic                  output1,
	output logic                  output2,
	output logic                  setup_fault
);
	// ----------------------------------------------------------------
	// registers and apb slave
	// ----------------------------------------------------------------
	logic [3:0]       mode_r, mode_nxt;
	logic             frst_en_r, frst_en_nxt;
	logic [CNT_W-1:0] sp1_r, sp1_nxt, sp2_r, sp2_nxt;
	logic [PW_W-1:0]  pw_r [2];
	logic [PW_W-1:0]  pw_nxt [2];
	logic             fault_r, fault_nxt, checked_r, checked_nxt;
	logic [31:0]      prdata_r, prdata_nxt, rd_val;
	logic             pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic             wr_en, mapped, key_rst, accept;
	logic             chk_done, chk_bad, tick;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	run_state_e       st_r, st_nxt;
	wire  [1:0]       out_q, pend;

	assign wr_en  = psel && penable && pwrite && pready_r;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFF_CMD);
	assign key_rst = wr_en && (paddr == OFF_CMD) &&
		pwdata[CMD_RESET_BIT] && frst_en_r;
	assign accept = wr_en && (paddr == OFF_CMD) && pwdata[CMD_ACCEPT_BIT];

	function automatic logic [PW_W-1:0] clamp_pw(input logic [31:0] d);
		if (d < {18'h0, PULSE_MIN})
			return PULSE_MIN;
		if (d > {18'h0, PULSE_MAX})
			return PULSE_MAX;
		return d[PW_W-1:0];
	endfunction : clamp_pw

	function automatic logic [CNT_W-1:0] clamp_sp(input logic [31:0] d);
		return (d > {12'h0, COUNT_MAX}) ? COUNT_MAX : d[CNT_W-1:0];
	endfunction : clamp_sp

	always_comb begin
		unique case (paddr)
			OFF_CTRL:  rd_val = {27'h0, frst_en_r, mode_r};
			OFF_SP1:   rd_val = {12'h0, sp1_r};
			OFF_SP2:   rd_val = {12'h0, sp2_r};
			OFF_PW1:   rd_val = {18'h0, pw_r[0]};
			OFF_PW2:   rd_val = {18'h0, pw_r[1]};
			OFF_STAT:  rd_val = {27'h0, st_r == ST_WAIT, !run_in_n,
				fault_r, out_q};
			OFF_COUNT: rd_val = {12'h0, cnt_r};
			default:   rd_val = 32'h0;
		endcase
	end

	always_comb begin
		mode_nxt    = mode_r;
		frst_en_nxt = frst_en_r;
		sp1_nxt     = sp1_r;
		sp2_nxt     = sp2_r;
		pw_nxt      = pw_r;
		pready_nxt  = psel && !penable;
		pslverr_nxt = psel && !penable && !mapped;
		prdata_nxt  = (psel && !penable) ? rd_val : prdata_r;
		checked_nxt = 1'b1;
		fault_nxt   = fault_r;
		if (wr_en) begin
			unique case (paddr)
				OFF_CTRL: begin
					mode_nxt    = pwdata[3:0];
					frst_en_nxt = pwdata[CTRL_FRST_BIT];
				end
				OFF_SP1: sp1_nxt = clamp_sp(pwdata);
				OFF_SP2: sp2_nxt = clamp_sp(pwdata);
				OFF_PW1: pw_nxt[0] = clamp_pw(pwdata);
				OFF_PW2: pw_nxt[1] = clamp_pw(pwdata);
				default: ;
			endcase
		end
		// a fault found in the same cycle as accept still stands
		if (accept)
			fault_nxt = 1'b0;
		if (chk_done && chk_bad)
			fault_nxt = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_r    <= DUAL ? MODE_RST_DUAL : MODE_RST_SINGLE;
			frst_en_r <= FRST_RST;
			sp1_r     <= SP1_RST;
			sp2_r     <= SP2_RST;
			pw_r[0]   <= PW_RST;
			pw_r[1]   <= PW_RST;
			fault_r   <= 1'b0;
			checked_r <= 1'b0;
			prdata_r  <= 32'h0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			mode_r    <= mode_nxt;
			frst_en_r <= frst_en_nxt;
			sp1_r     <= sp1_nxt;
			sp2_r     <= sp2_nxt;
			pw_r      <= pw_nxt;
			fault_r   <= fault_nxt;
			checked_r <= checked_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tick    (tick)
	);

	setup_check u_check (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (!checked_r),
		.dual    (DUAL),
		.mode    (mode_r),
		.sp1     (sp1_r),
		.sp2     (sp2_r),
		.pw1     (pw_r[0]),
		.pw2     (pw_r[1]),
		.ref_sum (nv_sum),
		.done    (chk_done),
		.bad     (chk_bad)
	);

	// ----------------------------------------------------------------
	// elapsed-time counter and mode sequencer
	// ----------------------------------------------------------------
	logic             legal, count_down_reload_style, man, ext_low;
	logic             adv, hit_a, hit_b, clr, go_wait, wait_end;
	logic [CNT_W-1:0] start_val, cnt_step, top;
	logic [1:0]       set_lat, set_pls, off;

	assign legal    = mode_legal(DUAL, mode_r);
	assign count_down_reload_style = mode_down(DUAL, mode_r);
	assign top       = DUAL ? sp2_r : sp1_r;
	assign start_val = count_down_reload_style ? top : '0;
	assign cnt_step  = count_down_reload_style ? cnt_r - CNT_W'(1) :
		cnt_r + CNT_W'(1);
	assign ext_low  = !external_clear_input_n;
	assign man      = key_rst || ext_low;
	assign adv      = tick && !run_in_n && legal && (st_r == ST_RUN);
	assign hit_a    = adv && DUAL && (cnt_step == sp1_r);
	assign hit_b    = adv && (count_down_reload_style ?
		(cnt_step == '0) : (cnt_step == top));
	assign wait_end = DUAL ? pend[1] : pend[0];

	always_comb begin
		set_lat = '0;
		set_pls = '0;
		off     = '0;
		clr     = 1'b0;
		go_wait = 1'b0;
		if (DUAL) begin
			unique case (mode_r)
				4'h2, 4'ha: begin
					set_lat[0] = hit_a;
					off[0]     = hit_b;
					set_lat[1] = hit_b;
				end
				4'h3, 4'hb: begin
					set_lat[0] = hit_a;
					off[0]     = hit_b;
					set_pls[1] = hit_b;
				end
				4'h4: begin
					set_lat[0] = hit_a;
					off[0]     = hit_b;
					set_pls[1] = hit_b;
					clr        = 1'b1;
				end
				4'h5: begin
					set_pls    = {hit_b, hit_a};
					clr        = 1'b1;
				end
				4'h6: begin
					set_lat[0] = hit_a;
					off[0]     = hit_b;
					set_pls[1] = hit_b;
					go_wait    = hit_b;
				end
				4'h7: begin
					set_pls    = {hit_b, hit_a};
					go_wait    = hit_b;
				end
				4'h8: set_lat = {hit_b, hit_a};
				4'h9: set_pls = {hit_b, hit_a};
				default: off = 2'b11;
			endcase
		end else begin
			unique case (mode_r)
				4'h0: set_lat[0] = hit_b;
				4'h1: set_pls[0] = hit_b;
				4'h4: begin
					set_pls[0] = hit_b;
					clr        = 1'b1;
				end
				4'h6: begin
					set_pls[0] = hit_b;
					go_wait    = hit_b;
				end
				4'h8: set_lat[0] = hit_b;
				default: off = 2'b11;
			endcase
		end
	end

	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		unique case (st_r)
			ST_RUN: begin
				if (adv) begin
					cnt_nxt = (clr && hit_b) ? '0 : cnt_step;
					if (go_wait)
						st_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (wait_end) begin
					cnt_nxt = '0;
					st_nxt  = ST_RUN;
				end
			end
			ST_HOLD: st_nxt = ST_RUN;
			default: st_nxt = ST_RUN;
		endcase
		if (man) begin
			cnt_nxt = start_val;
			st_nxt  = ext_low ? ST_HOLD : ST_RUN;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r  <= ST_RUN;
			cnt_r <= '0;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// output channels: latched level or timed pulse
	// ----------------------------------------------------------------
	// pulse time runs on the timebase even when the run input is off
	for (genvar g = 0; g < 2; g++) begin : g_chan
		logic            o_r, o_nxt;
		logic [PW_W-1:0] rem_r, rem_nxt;

		always_comb begin
			o_nxt   = o_r;
			rem_nxt = rem_r;
			if (tick && (rem_r != '0)) begin
				rem_nxt = rem_r - PW_W'(1);
				if (rem_r == PW_W'(1))
					o_nxt = 1'b0;
			end
			if (off[g]) begin
				o_nxt   = 1'b0;
				rem_nxt = '0;
			end
			if (set_lat[g]) begin
				o_nxt   = 1'b1;
				rem_nxt = '0;
			end
			if (set_pls[g]) begin
				o_nxt   = 1'b1;
				rem_nxt = pw_r[g];
			end
			if (man) begin
				o_nxt   = 1'b0;
				rem_nxt = '0;
			end
		end

		always_ff @(posedge clk) begin
			if (sys_rst) begin
				o_r   <= 1'b0;
				rem_r <= '0;
			end else begin
				o_r   <= o_nxt;
				rem_r <= rem_nxt;
			end
		end

		assign out_q[g] = o_r;
		assign pend[g]  = tick && (rem_r == PW_W'(1));
	end

	assign output1     = out_q[0];
	assign output2     = out_q[1];
	assign setup_fault = fault_r;
	assign prdata      = prdata_r;
	assign pready      = pready_r;
	assign pslverr     = pslverr_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_single_restart:
	assert property (!DUAL && mode_r == 4'h6 && st_r == ST_WAIT &&
		wait_end && !man |=> cnt_r == '0 && !out_q[0] && st_r == ST_RUN)
		else $error("single mode 6 did not restart after pulse");
	a_single_latch:
	assert property (!DUAL && mode_r == 4'h8 && hit_b && !man
		|=> out_q[0] ##1 (out_q[0] || $past(man)))
		else $error("single mode 8 output did not latch at zero");
	a_unused_mode:
	assert property (!legal && !man |=> !out_q[0] && !out_q[1] &&
		$stable(cnt_r))
		else $error("unused mode drove an output or counted");
	a_dual_latch:
	assert property (DUAL && mode_r == 4'h2 && hit_b && !man
		|=> !out_q[0] && out_q[1])
		else $error("mode 2 outputs wrong at setpoint two");
	a_auto_zero:
	assert property (DUAL && (mode_r == 4'h4 || mode_r == 4'h5) &&
		hit_b && !man |=> cnt_r == '0 && out_q[1])
		else $error("count not cleared at setpoint two");
	a_wait_freeze:
	assert property (DUAL && (mode_r == 4'h6 || mode_r == 4'h7) &&
		hit_b && !man |=> st_r == ST_WAIT && out_q[1] && !tick [*1]
		##1 $stable(cnt_r) || st_r != ST_WAIT)
		else $error("count moved while waiting for pulse end");
	a_manual_reset:
	assert property (man |=> cnt_r == $past(start_val) &&
		!out_q[0] && !out_q[1])
		else $error("manual reset did not restart the cycle");
	a_remote_hold:
	assert property (ext_low [*2] |-> st_r == ST_HOLD && !out_q[0] &&
		!out_q[1])
		else $error("remote reset held but unit not held");
	a_run_gate:
	assert property (run_in_n && !man && st_r != ST_WAIT
		|=> $stable(cnt_r))
		else $error("count moved with run input off");
	a_pulse_range:
	assert property (pw_r[0] >= PULSE_MIN && pw_r[0] <= PULSE_MAX &&
		pw_r[1] >= PULSE_MIN && pw_r[1] <= PULSE_MAX)
		else $error("pulse duration out of range");
	a_fault_raise:
	assert property (chk_done && chk_bad |=> setup_fault)
		else $error("fault flag not raised by failed check");
	a_fault_accept:
	assert property (accept && !(chk_done && chk_bad) |=> !setup_fault)
		else $error("accept did not clear the fault flag");

	c_wait_end: cover property (st_r == ST_WAIT ##1 st_r == ST_RUN);
	c_hit_two:  cover property (hit_b && out_q[0]);
	c_fault:    cover property (chk_done && chk_bad);
	c_manual:   cover property (key_rst && out_q != 2'b00);
endmodule : preset_timer

// *** logic/timer_pkg.sv ***
// shared constants, types and helpers for the preset mode timer
package timer_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_NS   = 8;
	localparam int unsigned TICK_NS  = 10_000_000;  // 0.01 s timebase
	localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int unsigned CNT_W = 20;
	localparam int unsigned PW_W  = 14;
	localparam int unsigned SUM_W = 16;

	// ----------------------------------------------------------------
	// register map (byte offsets)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_SP1   = 8'h04;
	localparam logic [7:0] OFF_SP2   = 8'h08;
	localparam logic [7:0] OFF_PW1   = 8'h0c;
	localparam logic [7:0] OFF_PW2   = 8'h10;
	localparam logic [7:0] OFF_STAT  = 8'h14;
	localparam logic [7:0] OFF_COUNT = 8'h18;
	localparam logic [7:0] OFF_CMD   = 8'h1c;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_FRST_BIT  = 4;
	localparam int unsigned CMD_RESET_BIT  = 0;
	localparam int unsigned CMD_ACCEPT_BIT = 1;
	localparam logic [3:0]       MODE_RST_DUAL   = 4'h2;
	localparam logic [3:0]       MODE_RST_SINGLE = 4'h0;
	localparam logic             FRST_RST        = 1'b1;
	localparam logic [CNT_W-1:0] SP1_RST         = 20'h001f4;
	localparam logic [CNT_W-1:0] SP2_RST         = 20'h003e8;
	localparam logic [PW_W-1:0]  PW_RST          = 14'h000a;
	localparam logic [CNT_W-1:0] COUNT_MAX       = 20'hf423f;
	localparam logic [PW_W-1:0]  PULSE_MIN       = 14'h0001;
	localparam logic [PW_W-1:0]  PULSE_MAX       = 14'h270f;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_WAIT = 2'b01,
		ST_HOLD = 2'b11
	} run_state_e;

	function automatic logic mode_legal(input logic dual,
			input logic [3:0] m);
		if (dual)
			return (m >= 4'h2) && (m <= 4'hb);
		return (m == 4'h0) || (m == 4'h1) || (m == 4'h4) ||
			(m == 4'h6) || (m == 4'h8);
	endfunction : mode_legal

	function automatic logic mode_down(input logic dual,
			input logic [3:0] m);
		if (dual)
			return (m >= 4'h8) && (m <= 4'hb);
		return m == 4'h8;
	endfunction : mode_down

endpackage : timer_pkg

// *** logic/tick_gen.sv ***
// timebase divider: one-cycle enable every CYCLES clocks
`timescale 1ns/10ps
module tick_gen
	import timer_pkg::*;
#(
	parameter int unsigned CYCLES = TICK_CYC
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	output logic      tick
);
	localparam int unsigned W = (CYCLES > 2) ? $clog2(CYCLES) : 1;
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] div_r, div_nxt;
	logic         tick_r, tick_nxt;

	always_comb begin
		tick_nxt = (div_r == LAST);
		div_nxt  = tick_nxt ? '0 : div_r + W'(1);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			div_r  <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule : tick_gen

// *** logic/setup_check.sv ***
// power-up integrity check of the stored set-up words
`timescale 1ns/10ps
module setup_check
	import timer_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             start,
	input  wire logic             dual,
	input  wire logic [3:0]       mode,
	input  wire logic [CNT_W-1:0] sp1,
	input  wire logic [CNT_W-1:0] sp2,
	input  wire logic [PW_W-1:0]  pw1,
	input  wire logic [PW_W-1:0]  pw2,
	input  wire logic [SUM_W-1:0] ref_sum,
	output logic                  done,
	output logic                  bad
);
	logic [SUM_W-1:0] sum;
	logic             bad_now;
	logic             done_r, done_nxt;
	logic             bad_r, bad_nxt;

	// xor fold keeps the check to one cycle; it catches bit flips only
	always_comb begin
		sum = {12'h000, mode} ^ sp1[15:0] ^ {12'h000, sp1[19:16]} ^
			sp2[15:0] ^ {12'h000, sp2[19:16]} ^ {2'h0, pw1} ^
			{2'h0, pw2};
		bad_now = (sum != ref_sum) || !mode_legal(dual, mode) ||
			(sp1 > COUNT_MAX) || (sp2 > COUNT_MAX) ||
			(pw1 < PULSE_MIN) || (pw1 > PULSE_MAX) ||
			(pw2 < PULSE_MIN) || (pw2 > PULSE_MAX);
		done_nxt = start;
		bad_nxt  = start ? bad_now : bad_r;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			done_r <= 1'b0;
			bad_r  <= 1'b0;
		end else begin
			done_r <= done_nxt;
			bad_r  <= bad_nxt;
		end
	end

	assign done = done_r;
	assign bad  = bad_r;
endmodule : setup_check

// *** verif/field_side.sv ***
// far-side model: run contact, remote clear switch and output loads
`timescale 1ns/10ps
module field_side (
	input  wire logic       clk,
	input  wire logic       run_req,
	input  wire logic       clr_req,
	input  wire logic       output1,
	input  wire logic       output2,
	output logic            run_in_n = 1'b1,
	output logic            external_clear_input_n = 1'b1,
	output logic [1:0]      load_on
);
	// ----------------------------------------------------------------
	// contacts
	// ----------------------------------------------------------------
	// a closed contact pulls the line to common, an open one floats high
	always_ff @(posedge clk) begin
		run_in_n               <= !run_req;
		external_clear_input_n <= !clr_req;
	end

	// loads simply follow the drive lines
	assign load_on = {output2, output1};
endmodule : field_side

// *** verif/tb_top.sv ***
// self-checking bench for the preset mode timer
`timescale 1ns/10ps
module tb_top;
	import timer_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	// short timebase keeps every pulse and count step a few clocks apart
	localparam int unsigned TK = 4;
	logic             clk     = 1'b0;
	logic             sys_rst = 1'b1;
	logic             psel    = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite  = 1'b0;
	logic [7:0]       paddr   = 8'h00;
	logic [31:0]      pwdata  = 32'h0;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic             run_req = 1'b0;
	logic             clr_req = 1'b0;
	logic             run_in_n;
	logic             external_clear_input_n;
	logic             output1;
	logic             output2;
	logic             setup_fault;
	logic [SUM_W-1:0] nv_sum  = 16'h0000;
	logic [1:0]       load_on;
	logic [1:0]       prev_out = 2'h0;
	logic [1:0]       expq[$];
	logic [31:0]      rd;
	logic             err;
	logic [15:0]      lfsr = 16'h0024;
	logic [31:0]      v;
	int               errors = 0;
	int               samples_checked = 0;

	always #4 clk = ~clk;

	preset_timer #(.DUAL(1'b1), .TICK_CYCLES(TK)) uut (
		.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.run_in_n(run_in_n),
		.external_clear_input_n(external_clear_input_n),
		.nv_sum(nv_sum), .output1(output1), .output2(output2),
		.setup_fault(setup_fault));

	field_side partner (
		.clk(clk), .run_req(run_req), .clr_req(clr_req),
		.output1(output1), .output2(output2), .run_in_n(run_in_n),
		.external_clear_input_n(external_clear_input_n),
		.load_on(load_on));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict;
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr_next

	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			errors++;
			$display("MISMATCH t=%0t no bus answer", $time);
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rchk

	task automatic ticks(input int n);
		repeat (n * TK) @(posedge clk);
	endtask : ticks

	// waits for the watcher to consume every noted output event
	task automatic drain;
		int n;
		n = 0;
		while (expq.size() != 0 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (expq.size() != 0) begin
			errors++;
			$display("MISMATCH t=%0t output events missing", $time);
			give_verdict();
		end
	endtask : drain

	// ----------------------------------------------------------------
	// output watcher
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (!sys_rst && load_on !== prev_out) begin
			prev_out <= load_on;
			if (expq.size() == 0)
				chk(32'(load_on), 32'(prev_out));
			else
				chk(32'(load_on), 32'(expq.pop_front()));
		end
	end

	// sp1=3, sp2=5, pulses 1 tick: k events noted in s, low pair first
	task automatic run_mode(input int m);
		logic [7:0]  s;
		int          k;
		logic [31:0] st;
		case (m)
		2, 10: begin k = 2; s = 8'h09; end
		8: begin k = 2; s = 8'h0d; end
		5, 7, 9: begin k = 4; s = 8'h21; end
		default: begin k = 3; s = 8'h09; end
		endcase
		st = (m >= 8) ? 32'h5 : 32'h0;
		apb(1'b1, OFF_CTRL, 32'h10 | 32'(m));
		apb(1'b1, OFF_CMD, 32'h1);
		ticks(5);
		rchk(OFF_COUNT, st);
		for (int i = 0; i < k; i++)
			expq.push_back(s[2*i +: 2]);
		run_req <= 1'b1;
		drain();
		run_req <= 1'b0;
		if (s[2*k-2 +: 2] != 2'h0)
			expq.push_back(2'h0);
		if (m % 2 == 0) begin
			clr_req <= 1'b1;
			ticks(2);
			rchk(OFF_COUNT, st);
			clr_req <= 1'b0;
		end else
			apb(1'b1, OFF_CMD, 32'h1);
		drain();
		rchk(OFF_COUNT, st);
		$display("mode %0d test done", m);
	endtask : run_mode

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk({31'h0, setup_fault}, 32'h1);
		rchk(OFF_STAT, 32'h4);
		apb(1'b1, OFF_CMD, 32'h2);
		rchk(OFF_STAT, 32'h0);
		chk({31'h0, setup_fault}, 32'h0);
		$display("fault flag test done");

		nv_sum  <= 16'h021e;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk({31'h0, setup_fault}, 32'h0);
		rchk(OFF_CTRL, 32'h12);
		rchk(OFF_SP1, 32'h1f4);
		rchk(OFF_SP2, 32'h3e8);
		rchk(OFF_PW2, 32'ha);
		rchk(OFF_COUNT, 32'h0);
		rchk(OFF_CMD, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("register reset test done");

		for (int i = 0; i < 3; i++) begin
			lfsr = lfsr_next(lfsr);
			v = 32'(lfsr % 16'd9999) + 32'h1;
			apb(1'b1, OFF_PW1, v);
			rchk(OFF_PW1, v);
		end
		apb(1'b1, OFF_PW1, 32'h0);
		rchk(OFF_PW1, 32'h1);
		apb(1'b1, OFF_PW1, 32'h4e20);
		rchk(OFF_PW1, 32'h270f);
		$display("pulse width test done");

		apb(1'b1, OFF_SP1, 32'hfffff);
		rchk(OFF_SP1, 32'hf423f);
		apb(1'b1, OFF_SP1, 32'h3);
		apb(1'b1, OFF_SP2, 32'h5);
		apb(1'b1, OFF_PW1, 32'h1);
		apb(1'b1, OFF_PW2, 32'h1);
		for (int m = 2; m <= 11; m++)
			run_mode(m);

		// front reset key disabled: the command must leave the count alone
		apb(1'b1, OFF_CTRL, 32'h2);
		apb(1'b1, OFF_CMD, 32'h1);
		rchk(OFF_COUNT, 32'h5);

		// mode 0 is single-only: nothing may count or switch
		apb(1'b1, OFF_CTRL, 32'h10);
		run_req <= 1'b1;
		ticks(10);
		rchk(OFF_COUNT, 32'h5);
		run_req <= 1'b0;
		$display("unused mode test done");
		give_verdict();
	end
endmodule : tb_top
